// ---- inc/cpf_map.vh ----
// constants for the cam profile follower
`ifndef CPF_MAP_VH
`define CPF_MAP_VH
// ***************************************************************
// register offsets (byte addresses)
// ***************************************************************
`define CPF_OFS_CTRL 8'h00
`define CPF_OFS_CMD 8'h04
`define CPF_OFS_OFFSET 8'h08
`define CPF_OFS_PPR 8'h0c
`define CPF_OFS_POINT 8'h10
`define CPF_OFS_STATUS 8'h14
`define CPF_OFS_SUBPOS 8'h18
`define CPF_OFS_TADDR 8'h1c
`define CPF_OFS_TDATA 8'h20
`define CPF_OFS_MAINPOS 8'h24
// ***************************************************************
// command register fields
// ***************************************************************
`define CPF_CMD_GO 0
`define CPF_CMD_OFS 1
`define CPF_CMD_STOP 2
`define CPF_CMD_AXIS_LSB 4
`define CPF_CMD_BLK_LSB 8
`define CPF_CMD_SUBU_LSB 12
// ***************************************************************
// limits, units and error codes
// ***************************************************************
`define CPF_BLOCKS 9
`define CPF_ENTRIES 2048
`define CPF_PPR_MAX 32'd200000000
`define CPF_PPR_RST 32'd3600
`define CPF_POINT_RST 32'd10
`define CPF_UNIT_DEG 2'd3
`define CPF_USER_BLK 4'd8
`define CPF_ERR_MCODE 16'd702
`define CPF_ERR_AXIS 16'd704
`define CPF_ERR_UNIT 16'd705
`define CPF_ERR_TABLE 16'd706
`define CPF_ERR_SPEED 16'd708
`endif

// ---- verilog/cpf_follower.v ----
// cam profile follower: main axis tracking through stored cam tables

`include "cpf_map.vh"
`timescale 1ns/10ps
`default_nettype none

module cpf_follower #(
  parameter ADDR_W = 8,
  parameter SPEED_LIMIT = 32'd1000
) (
  input wire core_clk_in,
  input wire reset_n_in,
  input wire [ADDR_W-1:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  input wire [127:0] axis_pos_in,
  input wire mcode_on_in,
  output reg [31:0] sub_pos_out,
  output reg running_out,
  output reg error_out
);

// ***************************************************************
// pin synchroniser for m code flag
// ***************************************************************
reg [2:0] mc_sync_reg;
reg mc_reg;
always @(posedge core_clk_in)
begin
  if (!reset_n_in)
  begin
    mc_sync_reg <= 3'h0;
    mc_reg <= 1'b0;
  end
  else
  begin
    mc_sync_reg <= {mc_sync_reg[1:0], mcode_on_in};
    // the last two flops must agree, so a single sampled glitch never counts
    if (mc_sync_reg[2] == mc_sync_reg[1])
      mc_reg <= mc_sync_reg[1];
  end
end

// ***************************************************************
// cam table storage
// ***************************************************************
// nine blocks of storage
// sections, curves and continuity are folded into the table contents
// continuity is held by software loading adjacent entries
// curve samples are precomputed per point step
reg [31:0] table_mem [0:`CPF_BLOCKS*`CPF_ENTRIES-1];
reg [3:0] blk_reg;
reg [1:0] axis_reg;
reg [1:0] subu_reg;
reg [31:0] ppr_reg;
reg [31:0] point_reg;
reg [31:0] offset_reg;
reg [31:0] taddr_reg;
reg [31:0] base_reg;
reg [31:0] rot_reg;
reg [31:0] prev_main_reg;
reg waiting_reg;
reg [15:0] err_reg;
reg [31:0] div_q_reg;
reg [31:0] div_r_reg;
reg [31:0] e0_reg;
reg [31:0] e1_reg;
reg [1:0] ph_reg;

localparam PH_IDLE = 2'd0;
localparam PH_FETCH = 2'd1;
localparam PH_MIX = 2'd2;

wire [31:0] main_now = axis_pos_in[axis_reg*32 +: 32];
wire cmd_wr = wr_in && (addr_in == `CPF_OFS_CMD);
wire [2:0] cmd_axis = wdata_in[`CPF_CMD_AXIS_LSB +: 3];
wire [3:0] cmd_blk = wdata_in[`CPF_CMD_BLK_LSB +: 4];
wire [1:0] cmd_subu = wdata_in[`CPF_CMD_SUBU_LSB +: 2];
wire [15:0] idx_tbl = (ppr_reg / point_reg > `CPF_ENTRIES) ? 16'h0 : 16'h1;
wire [31:0] step_q = rot_reg / point_reg;
wire [31:0] step_r = rot_reg % point_reg;
wire [31:0] row0 = ({28'h0, blk_reg} - 32'd1) * `CPF_ENTRIES;
wire [31:0] next_q = (div_q_reg + 32'd1 >= `CPF_ENTRIES) ? 32'h0 : div_q_reg + 32'd1;
wire signed [63:0] mix = $signed({{32{e1_reg[31]}}, e1_reg} - {{32{e0_reg[31]}}, e0_reg})
  * $signed({32'h0, div_r_reg});
// remainder is below one step, so the quotient always fits 32 bits
wire signed [63:0] mix_quo = mix / $signed({32'h0, point_reg});
wire [31:0] mix_div = mix_quo[31:0];
wire [31:0] new_sub = e0_reg + mix_div;
wire [31:0] delta = (new_sub > sub_pos_out) ? new_sub - sub_pos_out : sub_pos_out - new_sub;
// difference form keeps working across a 32-bit position roll-over
wire [31:0] rot_inc = rot_reg + (main_now - prev_main_reg);

// ***************************************************************
// start command screening
// ***************************************************************
// first failing check wins; zero means the start is accepted
reg [15:0] go_err_code;
always @*
begin
  go_err_code = 16'h0;
  if (mc_reg)
    go_err_code = `CPF_ERR_MCODE;
  else if (cmd_axis == 3'h0 || cmd_axis > 3'h4)
    go_err_code = `CPF_ERR_AXIS;
  else if (cmd_subu == `CPF_UNIT_DEG)
    go_err_code = `CPF_ERR_UNIT;
  else if (cmd_blk == 4'h0 || cmd_blk > `CPF_USER_BLK)
    go_err_code = `CPF_ERR_TABLE;
  else if (idx_tbl == 16'h0)
    go_err_code = `CPF_ERR_TABLE;
end

// ***************************************************************
// settings and table address
// ***************************************************************
always @(posedge core_clk_in)
begin
  if (!reset_n_in)
  begin
    ppr_reg <= `CPF_PPR_RST;
    point_reg <= `CPF_POINT_RST;
    offset_reg <= 32'h0;
    taddr_reg <= 32'h0;
  end
  else
  begin
    if (wr_in && addr_in == `CPF_OFS_OFFSET)
      offset_reg <= wdata_in;
    if (wr_in && addr_in == `CPF_OFS_PPR && wdata_in != 32'h0 && wdata_in <= `CPF_PPR_MAX)
      ppr_reg <= wdata_in;
    // a zero step would divide by zero in the index path
    if (wr_in && addr_in == `CPF_OFS_POINT && wdata_in != 32'h0)
      point_reg <= wdata_in;
    if (wr_in && addr_in == `CPF_OFS_TADDR)
      taddr_reg <= wdata_in;
    // auto increment lets software stream a whole block
    if (wr_in && addr_in == `CPF_OFS_TDATA)
      taddr_reg <= taddr_reg + 32'd1;
  end
end

// ***************************************************************
// command and register writes
// ***************************************************************
always @(posedge core_clk_in)
begin
  if (!reset_n_in)
  begin
    blk_reg <= 4'h1;
    axis_reg <= 2'h0;
    subu_reg <= 2'h0;
    running_out <= 1'b0;
    waiting_reg <= 1'b0;
    err_reg <= 16'h0;
    base_reg <= 32'h0;
    rot_reg <= 32'h0;
    sub_pos_out <= 32'h0;
    ph_reg <= PH_IDLE;
    div_q_reg <= 32'h0;
    div_r_reg <= 32'h0;
    e0_reg <= 32'h0;
    e1_reg <= 32'h0;
  end
  else
  begin
    if (cmd_wr && wdata_in[`CPF_CMD_STOP])
    begin
      running_out <= 1'b0;
      waiting_reg <= 1'b0;
      ph_reg <= PH_IDLE;
    end
    else if (cmd_wr && wdata_in[`CPF_CMD_GO])
    begin
      // refusal code comes from the screening logic above
      if (go_err_code != 16'h0)
        err_reg <= go_err_code;
      else
      begin
        axis_reg <= cmd_axis[1:0] - 2'd1;
        blk_reg <= cmd_blk;
        subu_reg <= cmd_subu;
        err_reg <= 16'h0;
        waiting_reg <= wdata_in[`CPF_CMD_OFS];
        running_out <= 1'b1;
        rot_reg <= 32'h0;
        ph_reg <= PH_IDLE;
      end
    end
    if (cmd_wr && wdata_in[`CPF_CMD_GO] && !wdata_in[`CPF_CMD_STOP])
      base_reg <= main_now;
    if (running_out && !(cmd_wr && wdata_in[`CPF_CMD_STOP]))
    begin
      if (waiting_reg)
      begin
        // exact match only; a main axis that jumps past the offset keeps waiting
        if (main_now == offset_reg)
        begin
          waiting_reg <= 1'b0;
          base_reg <= main_now;
          rot_reg <= 32'h0;
        end
      end
      else
      begin
        // ppr register holds the per-rotation maximum for every unit
        if (rot_inc >= ppr_reg)
          rot_reg <= rot_inc - ppr_reg;
        else
          rot_reg <= rot_inc;
        case (ph_reg)
          PH_IDLE:
          begin
            div_q_reg <= step_q;
            div_r_reg <= step_r;
            ph_reg <= PH_FETCH;
          end
          PH_FETCH:
          begin
            e0_reg <= table_mem[row0 + div_q_reg];
            e1_reg <= table_mem[row0 + next_q];
            ph_reg <= PH_MIX;
          end
          PH_MIX:
          begin
            // speed limit error
            // one update spans three clocks, so the limit is per update
            if (delta > SPEED_LIMIT)
            begin
              err_reg <= `CPF_ERR_SPEED;
              running_out <= 1'b0;
            end
            else
              sub_pos_out <= new_sub;
            ph_reg <= PH_IDLE;
          end
          default:
            ph_reg <= PH_IDLE;
        endcase
      end
    end
  end
end

// ***************************************************************
// error flag and main position history
// ***************************************************************
always @(posedge core_clk_in)
begin
  if (!reset_n_in)
  begin
    error_out <= 1'b0;
    prev_main_reg <= 32'h0;
  end
  else
  begin
    // one cycle behind the status code, kept as a plain flop output
    error_out <= (err_reg != 16'h0);
    prev_main_reg <= main_now;
  end
end

// ***************************************************************
// table loading
// ***************************************************************
// section ends on point multiples are software duty
// last section spans rotation by software
// memory has no reset; software fills it before the first start
always @(posedge core_clk_in)
begin
  if (wr_in && addr_in == `CPF_OFS_TDATA && taddr_reg < `CPF_BLOCKS*`CPF_ENTRIES)
    table_mem[taddr_reg] <= wdata_in;
end

// ***************************************************************
// read mux
// ***************************************************************
always @(posedge core_clk_in)
begin
  if (!reset_n_in)
    rdata_out <= 32'h0;
  else if (rd_in)
  begin
    case (addr_in)
      `CPF_OFS_CTRL: rdata_out <= {28'h0, blk_reg};
      `CPF_OFS_CMD: rdata_out <= {18'h0, subu_reg, 8'h0, 2'h0, axis_reg};
      `CPF_OFS_OFFSET: rdata_out <= offset_reg;
      `CPF_OFS_PPR: rdata_out <= ppr_reg;
      `CPF_OFS_POINT: rdata_out <= point_reg;
      `CPF_OFS_STATUS: rdata_out <= {err_reg, 14'h0, waiting_reg, running_out};
      `CPF_OFS_SUBPOS: rdata_out <= sub_pos_out;
      `CPF_OFS_TADDR: rdata_out <= taddr_reg;
      `CPF_OFS_MAINPOS: rdata_out <= rot_reg;
      default: rdata_out <= 32'h0;
    endcase
  end
  else
    rdata_out <= 32'h0;
end
endmodule // cpf_follower
`default_nettype wire

// ---- tb/cpf_main_model.sv ----
// model of the main axis drives and the m code pin
`timescale 1ns/10ps
`default_nettype none
module cpf_main_model (
  input wire logic core_clk_in,
  input wire logic [31:0] pos_in,
  input wire logic mcode_in,
  output logic [127:0] axis_pos_out,
  output logic mcode_on_out
);
  logic [31:0] spin_reg = 32'h0;
  // axes 2..4 keep moving so a wrong pick shows
  always @(posedge core_clk_in)
  begin
    spin_reg <= spin_reg + 32'h1;
    axis_pos_out <= {~spin_reg, spin_reg, spin_reg ^ 32'h5a5a_0000, pos_in};
    mcode_on_out <= mcode_in;
  end
endmodule // cpf_main_model
`default_nettype wire

// ---- tb/cpf_follower_sva.sv ----
// assertion checker for the cam profile follower ports
`timescale 1ns/10ps
`default_nettype none
`include "cpf_map.vh"
module cpf_follower_sva #(
  parameter ADDR_W = 8,
  parameter SPEED_LIMIT = 32'd1000
) (
  input wire core_clk_in,
  input wire reset_n_in,
  input wire [ADDR_W-1:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [31:0] rdata_out,
  input wire [127:0] axis_pos_in,
  input wire mcode_on_in,
  input wire [31:0] sub_pos_out,
  input wire running_out,
  input wire error_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  wire cmd_wr = wr_in && addr_in == `CPF_OFS_CMD;
  wire go_ok = wdata_in[6:4] >= 3'd1 && wdata_in[6:4] <= 3'd4 && wdata_in[11:8] >= 4'd1
    && wdata_in[11:8] <= 4'd8 && wdata_in[13:12] != `CPF_UNIT_DEG;
  sequence s_go_wr; cmd_wr && wdata_in[0] && !wdata_in[2] && !running_out; endsequence
  sequence s_good_go; s_go_wr ##0 go_ok; endsequence
  // m code must be clear long enough to pass the 3-flop sync
  sequence s_mcode_clear; !mcode_on_in [*5]; endsequence
  property p_go_starts; s_mcode_clear ##0 s_good_go |=> running_out; endproperty
  a_go_starts: assert property (p_go_starts) else $error("good start did not run");
  property p_bad_refused; s_go_wr ##0 !go_ok |=> !running_out ##1 error_out; endproperty
  a_bad_refused: assert property (p_bad_refused) else $error("bad start not refused");
  property p_mcode_refused; mcode_on_in [*5] ##0 s_go_wr |=> !running_out; endproperty
  a_mcode_refused: assert property (p_mcode_refused) else $error("start ran with m code on");
  property p_stop; cmd_wr && wdata_in[2] |=> !running_out; endproperty
  a_stop: assert property (p_stop) else $error("stop left it running");
  property p_frozen; !running_out && $past(!running_out) |-> $stable(sub_pos_out); endproperty
  a_frozen: assert property (p_frozen) else $error("sub moved while stopped");
  property p_rise_cause; $rose(running_out) |-> $past(cmd_wr) && $past(wdata_in[0]); endproperty
  a_rise_cause: assert property (p_rise_cause) else $error("running without start");
  property p_read_quiet; !$past(rd_in) |-> rdata_out == 32'h0; endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read data outside read slot");
  property p_reset_quiet; $rose(reset_n_in) |-> !running_out && !error_out && sub_pos_out == 32'h0; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not clear after reset");
endmodule // cpf_follower_sva
bind cpf_follower cpf_follower_sva #(.ADDR_W(ADDR_W), .SPEED_LIMIT(SPEED_LIMIT)) sva_u (
  .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .axis_pos_in(axis_pos_in),
  .mcode_on_in(mcode_on_in), .sub_pos_out(sub_pos_out), .running_out(running_out), .error_out(error_out));
`default_nettype wire

// ---- tb/cpf_testbench.sv ----
// self-checking bench for the cam profile follower
`timescale 1ns/10ps
`default_nettype none
`include "cpf_map.vh"
module testbench;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] main_pos = 32'd5000;
  logic mcode = 1'b0;
  wire [31:0] rdata;
  wire [127:0] axis_pos;
  wire mcode_on;
  wire [31:0] sub_pos;
  wire running;
  wire err;
  logic [31:0] d;
  integer fail_count = 0;
  integer total_checks = 0;
  always #4 core_clk_in = ~core_clk_in;
  cpf_main_model main_u (.core_clk_in(core_clk_in), .pos_in(main_pos), .mcode_in(mcode),
    .axis_pos_out(axis_pos), .mcode_on_out(mcode_on));
  cpf_follower dut_u (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .axis_pos_in(axis_pos), .mcode_on_in(mcode_on),
    .sub_pos_out(sub_pos), .running_out(running), .error_out(err));
  task finish_test;
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      fail_count = fail_count + 1;
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk_in);
    wr <= 1'b0;
    #1;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge core_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task move(input logic [31:0] p);
    @(posedge core_clk_in);
    main_pos <= p;
    repeat (12) @(posedge core_clk_in);
  endtask
  task wait_sub(input logic [31:0] exp);
    integer i;
    i = 0;
    while (sub_pos !== exp && i < 40)
    begin
      @(posedge core_clk_in);
      #1 i = i + 1;
    end
    check(sub_pos, exp);
    if (i == 40)
      finish_test;
  endtask
  task t_regs;
    rd_reg(`CPF_OFS_PPR); check(d, `CPF_PPR_RST);
    rd_reg(`CPF_OFS_POINT); check(d, `CPF_POINT_RST);
    rd_reg(`CPF_OFS_STATUS); check(d, 32'h0);
    rd_reg(8'h40); check(d, 32'h0);
    // out of range settings must be ignored
    wr_reg(`CPF_OFS_PPR, 32'h0);
    wr_reg(`CPF_OFS_PPR, `CPF_PPR_MAX + 32'd1);
    wr_reg(`CPF_OFS_POINT, 32'h0);
    rd_reg(`CPF_OFS_PPR); check(d, `CPF_PPR_RST);
    rd_reg(`CPF_OFS_POINT); check(d, `CPF_POINT_RST);
  endtask
  task t_follow;
    integer n;
    // entries sit one point step of ten apart
    // motion wraps once past the 3600-count rotation and stays inside the loaded steps
    wr_reg(`CPF_OFS_TADDR, 32'h0);
    for (n = 0; n < 10; n = n + 1)
      wr_reg(`CPF_OFS_TDATA, n * 10);
    wr_reg(`CPF_OFS_CMD, 32'h0000_0111);
    check({31'h0, running}, 32'h1);
    move(32'd5073);
    wait_sub(32'd73);
    move(32'd8625);
    rd_reg(`CPF_OFS_MAINPOS); check(d, 32'd25);
    wait_sub(32'd25);
    wr_reg(`CPF_OFS_CMD, 32'h0000_0004);
    move(32'd8700);
    check(sub_pos, 32'd25);
    rd_reg(`CPF_OFS_STATUS); check(d, 32'h0);
  endtask
  task t_refuse;
    logic [31:0] cmds [0:5];
    logic [15:0] codes [0:5];
    integer k;
    cmds = '{32'h0001, 32'h0051, 32'h0011, 32'h0911, 32'h3111, 32'h0111};
    codes = '{`CPF_ERR_AXIS, `CPF_ERR_AXIS, `CPF_ERR_TABLE, `CPF_ERR_TABLE, `CPF_ERR_UNIT, `CPF_ERR_MCODE};
    for (k = 0; k < 6; k = k + 1)
    begin
      @(posedge core_clk_in);
      mcode <= (k == 5);
      repeat (6) @(posedge core_clk_in);
      wr_reg(`CPF_OFS_CMD, cmds[k]);
      rd_reg(`CPF_OFS_STATUS);
      check({d[31:16], 15'h0, d[0]}, {codes[k], 16'h0});
      check({31'h0, err}, 32'h1);
    end
    @(posedge core_clk_in);
    mcode <= 1'b0;
  endtask
  task t_offset;
    repeat (6) @(posedge core_clk_in);
    wr_reg(`CPF_OFS_OFFSET, 32'd6000);
    wr_reg(`CPF_OFS_CMD, 32'h0000_0113);
    rd_reg(`CPF_OFS_STATUS); check({30'h0, d[1:0]}, 32'h3);
    move(32'd6000);
    rd_reg(`CPF_OFS_STATUS); check({30'h0, d[1:0]}, 32'h1);
    wr_reg(`CPF_OFS_CMD, 32'h0000_0004);
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    t_regs;
    t_follow;
    t_refuse;
    t_offset;
    finish_test;
  end
endmodule // testbench
`default_nettype wire
